// ===== design/port_adc_result_regs.sv
// per-port conversion result registers behind an Avalon-MM slave
// Function
// RL1: voltage high byte at select 1001: complete flag bit 7, result bits 14..8.
// RL2: voltage complete flag clears when a voltage conversion starts.
// RL3: voltage complete flag sets when the voltage conversion finishes.
// RL4: current low byte at select 1010 carries result bits 7..0.
// RL5: current high byte at select 1011: complete flag bit 7, result bits 14..8.
// RL6: current complete flag clears when a current conversion starts.
// RL7: current complete flag sets when the current conversion finishes.
// RL8: temperature low byte at select 1100, result bits 7..0, resets to zero.
// RL9: all result bits and flags are read-only; writes change nothing.
// RL10: after reset both complete flags read 0, measurement active.
// RL11: low and high bytes of a result update together on completion.
`timescale 1ns/1ps
module port_adc_result_regs
#(
	parameter int NUM_PORTS = adc_result_pkg::NUM_PORTS
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [adc_result_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [adc_result_pkg::DATA_W-1:0] AVS_WRITEDATA,
	output logic [adc_result_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [NUM_PORTS-1:0] VOLT_START,
	input wire logic [NUM_PORTS-1:0] VOLT_DONE,
	input wire logic [NUM_PORTS*adc_result_pkg::RESULT_W-1:0] VOLT_RESULT,
	input wire logic [NUM_PORTS-1:0] CUR_START,
	input wire logic [NUM_PORTS-1:0] CUR_DONE,
	input wire logic [NUM_PORTS*adc_result_pkg::RESULT_W-1:0] CUR_RESULT,
	input wire logic [NUM_PORTS-1:0] TEMP_START,
	input wire logic [NUM_PORTS-1:0] TEMP_DONE,
	input wire logic [NUM_PORTS*adc_result_pkg::RESULT_W-1:0] TEMP_RESULT,
	output logic IRQ
);

	// ****************************************************************
	// local sizes and state
	// ****************************************************************
	localparam int RW = adc_result_pkg::RESULT_W;
	localparam int BW = adc_result_pkg::BYTE_W;
	localparam int DW = adc_result_pkg::DATA_W;
	localparam int IW = adc_result_pkg::IDX_W;
	localparam int SW = NUM_PORTS * adc_result_pkg::EVT_KINDS;
	localparam logic [SW-1:0] SW_ZERO = '0;

	typedef struct packed {
		logic hold;
		logic [DW-1:0] rdata;
		logic [SW-1:0] status;
		logic [SW-1:0] mask;
		logic irq;
	} regs_state_t;

	regs_state_t cur_ff;
	regs_state_t nxt_st;

	logic [RW-1:0] volt_res [NUM_PORTS];
	logic [RW-1:0] cur_res [NUM_PORTS];
	logic [RW-1:0] temp_res [NUM_PORTS];
	logic [NUM_PORTS-1:0] volt_flag;
	logic [NUM_PORTS-1:0] cur_flag;
	logic [IW-1:0] idx;
	logic req;
	logic accept;
	logic [SW-1:0] events;
	logic [BW-1:0] port_byte;
	logic [DW-1:0] read_word;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic hits(input logic [IW-1:0] at, input logic [IW-1:0] reg_idx);
		hits = (at == reg_idx);
	endfunction

	function automatic logic [BW-1:0] high_byte(input logic flag, input logic [RW-1:0] res);
		high_byte = {flag, res[RW-1:BW]};
	endfunction

	// ****************************************************************
	// result holders, one per port and measurement
	// ****************************************************************
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++)
		begin : g_port
			adc_result_chan u_volt
			(
				.CLK(CLK),
				.RST(RST),
				.start(VOLT_START[gp]),
				.done(VOLT_DONE[gp]),
				.data(VOLT_RESULT[gp*RW +: RW]),
				.result(volt_res[gp]),
				.complete(volt_flag[gp])
			);
			adc_result_chan u_cur
			(
				.CLK(CLK),
				.RST(RST),
				.start(CUR_START[gp]),
				.done(CUR_DONE[gp]),
				.data(CUR_RESULT[gp*RW +: RW]),
				.result(cur_res[gp]),
				.complete(cur_flag[gp])
			);
			// the temperature flag lives in the high byte, which this bank
			// does not present, so only the result is used
			adc_result_chan u_temp
			(
				.CLK(CLK),
				.RST(RST),
				.start(TEMP_START[gp]),
				.done(TEMP_DONE[gp]),
				.data(TEMP_RESULT[gp*RW +: RW]),
				.result(temp_res[gp]),
				.complete()
			);
		end
	endgenerate

	// ****************************************************************
	// address decode and read multiplexer
	// ****************************************************************
	assign idx = AVS_ADDRESS[adc_result_pkg::ADDR_W-1:2];
	assign req = AVS_READ | AVS_WRITE;
	assign accept = req & ~cur_ff.hold;

	always_comb
	begin
		logic [adc_result_pkg::PORT_W-1:0] port;
		logic [adc_result_pkg::SEL_W-1:0] sel;
		port = idx[adc_result_pkg::IDX_PORT_LSB +: adc_result_pkg::PORT_W];
		sel = idx[adc_result_pkg::IDX_SEL_LSB +: adc_result_pkg::SEL_W];
		port_byte = '0;
		// ports above the instantiated count read as zero
		if (int'(port) < NUM_PORTS)
		begin
			case (sel)
				adc_result_pkg::SEL_VOLT_LOW:
				begin
					port_byte = volt_res[port][BW-1:0];
				end
				adc_result_pkg::SEL_VOLT_HIGH:
				begin
					port_byte = high_byte(volt_flag[port], volt_res[port]); // see RL1
				end
				adc_result_pkg::SEL_CUR_LOW:
				begin
					port_byte = cur_res[port][BW-1:0]; // see RL4
				end
				adc_result_pkg::SEL_CUR_HIGH:
				begin
					port_byte = high_byte(cur_flag[port], cur_res[port]); // see RL5
				end
				adc_result_pkg::SEL_TEMP_LOW:
				begin
					port_byte = temp_res[port][BW-1:0]; // see RL8
				end
				default:
				begin
					port_byte = '0;
				end
			endcase
		end
	end

	always_comb
	begin
		read_word = '0;
		if (idx[adc_result_pkg::IDX_SHARED_BIT])
		begin
			if (hits(idx, adc_result_pkg::IDX_IRQ_STATUS))
			begin
				read_word[SW-1:0] = cur_ff.status;
			end
			else if (hits(idx, adc_result_pkg::IDX_IRQ_MASK))
			begin
				read_word[SW-1:0] = cur_ff.mask;
			end
		end
		else
		begin
			read_word[BW-1:0] = port_byte;
		end
	end

	// ****************************************************************
	// completion events, status bits index = port * 3 + kind
	// ****************************************************************
	always_comb
	begin
		events = '0;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			events[p*adc_result_pkg::EVT_KINDS + adc_result_pkg::EVT_VOLT] = VOLT_DONE[p];
			events[p*adc_result_pkg::EVT_KINDS + adc_result_pkg::EVT_CUR] = CUR_DONE[p];
			events[p*adc_result_pkg::EVT_KINDS + adc_result_pkg::EVT_TEMP] = TEMP_DONE[p];
		end
	end

	// ****************************************************************
	// bus handshake, interrupt status and mask
	// ****************************************************************
	always_comb
	begin
		nxt_st = cur_ff;
		// one wait cycle per access: the read word is captured while
		// waitrequest is high and presented on the edge it drops
		if (req && cur_ff.hold)
		begin
			nxt_st.hold = 1'b0;
			nxt_st.rdata = read_word;
		end
		else
		begin
			nxt_st.hold = adc_result_pkg::HOLD_RESET;
		end
		// only the bits the master actually saw are cleared, so an event
		// landing during the wait cycle is still pending afterwards
		if (accept && AVS_READ && hits(idx, adc_result_pkg::IDX_IRQ_STATUS))
		begin
			nxt_st.status = cur_ff.status & ~cur_ff.rdata[SW-1:0];
		end
		// result registers ignore writes; only the mask is writable
		if (accept && AVS_WRITE && hits(idx, adc_result_pkg::IDX_IRQ_MASK)) // see RL9
		begin
			nxt_st.mask = AVS_WRITEDATA[SW-1:0];
		end
		nxt_st.status = nxt_st.status | events;
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			cur_ff.hold <= adc_result_pkg::HOLD_RESET;
			cur_ff.rdata <= adc_result_pkg::RDATA_RESET;
			cur_ff.status <= SW_ZERO;
			cur_ff.mask <= SW_ZERO;
			cur_ff.irq <= 1'b0;
		end
		else
		begin
			cur_ff <= nxt_st;
		end
	end

	assign AVS_READDATA = cur_ff.rdata;
	assign AVS_WAITREQUEST = cur_ff.hold;
	assign IRQ = cur_ff.irq;

endmodule // port_adc_result_regs

// ===== design/adc_result_pkg.sv
// constants and types shared by the per-port conversion result register bank
package adc_result_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int RESULT_W = 15;
	localparam int BYTE_W = 8;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 9;
	localparam int SEL_W = 4;
	localparam int PORT_W = 2;
	localparam int NUM_PORTS = 4;
	localparam int EVT_KINDS = 3;

	// ****************************************************************
	// register select codes within one port (register index, byte address is 4x)
	// ****************************************************************
	localparam logic [SEL_W-1:0] SEL_VOLT_LOW = 4'h8;
	localparam logic [SEL_W-1:0] SEL_VOLT_HIGH = 4'h9;
	localparam logic [SEL_W-1:0] SEL_CUR_LOW = 4'hA;
	localparam logic [SEL_W-1:0] SEL_CUR_HIGH = 4'hB;
	localparam logic [SEL_W-1:0] SEL_TEMP_LOW = 4'hC;

	// ****************************************************************
	// word index layout: bit 6 set selects the shared registers,
	// otherwise bits 5:4 hold the port and bits 3:0 the select code
	// ****************************************************************
	localparam int IDX_W = ADDR_W - 2;
	localparam int IDX_SEL_LSB = 0;
	localparam int IDX_PORT_LSB = 4;
	localparam int IDX_SHARED_BIT = 6;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 7'h40;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 7'h41;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int FLAG_BIT = 7;
	localparam int EVT_VOLT = 0;
	localparam int EVT_CUR = 1;
	localparam int EVT_TEMP = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [RESULT_W-1:0] RESULT_RESET = 15'h0000;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic HOLD_RESET = 1'b1;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

	typedef struct packed {
		logic [RESULT_W-1:0] result;
		logic complete;
	} chan_state_t;

endpackage

// ===== design/adc_result_chan.sv
// one conversion result holder with its measurement-complete flag
`timescale 1ns/1ps
module adc_result_chan
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic start,
	input wire logic done,
	input wire logic [adc_result_pkg::RESULT_W-1:0] data,
	output logic [adc_result_pkg::RESULT_W-1:0] result,
	output logic complete
);

	adc_result_pkg::chan_state_t cur_ff;
	adc_result_pkg::chan_state_t nxt_st;

	always_comb
	begin
		nxt_st = cur_ff;
		if (start)
		begin
			nxt_st.complete = 1'b0; // see RL2 RL6
		end
		// completion wins over a start in the same cycle: the result just
		// finished is valid and must not be hidden behind an active flag
		if (done)
		begin
			// both bytes load on one edge so low and high always match
			nxt_st.result = data; // see RL11
			nxt_st.complete = 1'b1; // see RL3 RL7
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			cur_ff.result <= adc_result_pkg::RESULT_RESET; // see RL8
			cur_ff.complete <= adc_result_pkg::FLAG_RESET; // see RL10
		end
		else
		begin
			cur_ff <= nxt_st;
		end
	end

	assign result = cur_ff.result;
	assign complete = cur_ff.complete;

endmodule // adc_result_chan

// ===== dv/port_adc_result_regs_sva.sv
// concurrent checks on the ports of the result register bank
`timescale 1ns/1ps
module port_adc_result_regs_sva
#(
	parameter int NUM_PORTS = adc_result_pkg::NUM_PORTS
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [adc_result_pkg::DATA_W-1:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [NUM_PORTS-1:0] VOLT_DONE,
	input wire logic [NUM_PORTS-1:0] CUR_DONE,
	input wire logic [NUM_PORTS-1:0] TEMP_DONE,
	input wire logic IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ****
	// bus and interrupt
	// ****
	// the release edge still shows the request, so a fresh one needs a high wait before it
	sequence taken_s;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && $past(AVS_WAITREQUEST);
	endsequence
	sequence answer_s;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	wait_one_a: assert property (taken_s |=> answer_s)
		else $error("access not answered after one wait");
	wait_cause_a: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
		else $error("wait dropped with no access");
	data_hold_a: assert property (!$fell(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
		else $error("read data moved outside an answer");
	upper_zero_a: assert property (AVS_READDATA[31:12] == 20'h00000)
		else $error("unused read data bits set");
	reset_idle_a: assert property ($fell(RST) |-> !IRQ && AVS_WAITREQUEST)
		else $error("not idle after reset");
	irq_cause_a: assert property ($rose(IRQ) |-> $past(|{VOLT_DONE, CUR_DONE, TEMP_DONE})
		|| $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("interrupt rose with no event");
	irq_clear_a: assert property ($fell(IRQ) |-> $past(AVS_READ) || $past(AVS_READ, 2)
		|| $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("interrupt fell with no access");
	// a pending interrupt can only go away through a bus access
	irq_sticky_a: assert property (IRQ && !AVS_READ && !AVS_WRITE |=> IRQ)
		else $error("interrupt dropped with no access");
endmodule // port_adc_result_regs_sva

bind port_adc_result_regs port_adc_result_regs_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.CLK(CLK),
	.RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .VOLT_DONE(VOLT_DONE), .CUR_DONE(CUR_DONE),
	.TEMP_DONE(TEMP_DONE), .IRQ(IRQ));

// ===== dv/port_adc_result_regs_tb_top.sv
// self-checking bench for the result register bank
`timescale 1ns/1ps
module port_adc_result_regs_tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [8:0] addr = 9'h000;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic wait_req;
	logic irq;
	logic [3:0] st[3] = '{default: 4'h0};
	logic [3:0] dn[3] = '{default: 4'h0};
	logic [59:0] res[3] = '{default: 60'h0};
	int n_errors = 0;
	int checked = 0;
	always #5 clk = ~clk;
	port_adc_result_regs u_dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .VOLT_START(st[0]), .VOLT_DONE(dn[0]),
		.VOLT_RESULT(res[0]), .CUR_START(st[1]), .CUR_DONE(dn[1]), .CUR_RESULT(res[1]),
		.TEMP_START(st[2]), .TEMP_DONE(dn[2]), .TEMP_RESULT(res[2]), .IRQ(irq));
	// ****
	// helpers
	// ****
	function automatic logic [8:0] ra(input int p, input int s);
		return 9'(p * 64 + s * 4);
	endfunction
	function automatic logic [14:0] val(input int r, input int k, input int p);
		return 15'(16'h4A5C + r * 16'h03C3 + k * 16'h1111 + p * 16'h0202);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// request held until the edge that samples the wait low
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		repeat (50)
		begin
			@(posedge clk);
			if (wait_req === 1'h0)
				break;
		end
		q = rdata;
		if (wait_req !== 1'h0)
			n_errors++;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic reset_values();
		logic [31:0] q;
		for (int p = 0; p < 4; p++)
			for (int s = 9; s < 13; s++)
			begin
				bus(1'h0, ra(p, s), 32'h0, q);
				check(q, 32'h0);
			end
	endtask
	task automatic convert(input int k, input int p, input logic [14:0] v);
		logic [31:0] q;
		@(posedge clk);
		st[k][p] <= 1'h1;
		@(posedge clk);
		st[k][p] <= 1'h0;
		if (k < 2)
		begin
			bus(1'h0, ra(p, 9 + 2 * k), 32'h0, q);
			check({31'h0, q[7]}, 32'h0);
		end
		dn[k][p] <= 1'h1;
		res[k][p * 15 +: 15] <= v;
		@(posedge clk);
		dn[k][p] <= 1'h0;
		bus(1'h0, ra(p, 8 + 2 * k), 32'h0, q);
		check(q, {24'h0, v[7:0]});
		if (k < 2)
		begin
			bus(1'h0, ra(p, 9 + 2 * k), 32'h0, q);
			check(q, {24'h0, 1'h1, v[14:8]});
		end
	endtask
	task automatic conversions();
		for (int r = 0; r < 2; r++)
			for (int k = 0; k < 3; k++)
				for (int p = 0; p < 4; p++)
					convert(k, p, val(r, k, p));
	endtask
	task automatic read_only();
		logic [31:0] q;
		logic [14:0] v;
		bus(1'h1, ra(1, 9), 32'hFFFFFFFF, q);
		bus(1'h1, ra(2, 12), 32'hFFFFFFFF, q);
		v = val(1, 0, 1);
		bus(1'h0, ra(1, 9), 32'h0, q);
		check(q, {24'h0, 1'h1, v[14:8]});
		v = val(1, 2, 2);
		bus(1'h0, ra(2, 12), 32'h0, q);
		check(q, {24'h0, v[7:0]});
		bus(1'h0, ra(0, 0), 32'h0, q);
		check(q, 32'h0);
		bus(1'h0, 9'h1FC, 32'h0, q);
		check(q, 32'h0);
	endtask
	task automatic irq_flow();
		logic [31:0] q;
		bus(1'h1, 9'h104, 32'h1, q);
		bus(1'h0, 9'h100, 32'h0, q);
		convert(0, 0, 15'h7FFF);
		check({31'h0, irq}, 32'h1);
		bus(1'h0, 9'h100, 32'h0, q);
		check(q, 32'h1);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		convert(1, 0, 15'h0001);
		check({31'h0, irq}, 32'h0);
		bus(1'h0, 9'h100, 32'h0, q);
		check(q, 32'h2);
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		reset_values();
		conversions();
		read_only();
		irq_flow();
		print_verdict();
	end
	initial
	begin
		repeat (6000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
endmodule // port_adc_result_regs_tb_top
